// *** hdl/rgseq_cfg.svh ***
`ifndef RGSEQ_CFG_SVH
`define RGSEQ_CFG_SVH

// ****************************************
// Counter widths and reset defaults
// ****************************************
`define RGSEQ_CNT_W         16
`define RGSEQ_PRE_W         8
`define RGSEQ_CNT_ZERO      16'h0000
`define RGSEQ_BITS_PER_BYTE 16'h0008

`endif

// *** hdl/rgseq_pkg.sv ***
package rgseq_pkg;
    typedef enum logic [1:0] {
        RGSEQ_ALT1,
        RGSEQ_ALT2,
        RGSEQ_SOFT
    } rgseq_fmt_t;

    typedef enum logic [2:0] {
        RGSEQ_IDLE,
        RGSEQ_HDR_WAIT,
        RGSEQ_HDR_READ,
        RGSEQ_DAT_WAIT,
        RGSEQ_DAT_READ
    } rgseq_state_t;
endpackage : rgseq_pkg

// *** hdl/rgseq_bitcnt.sv ***
`include "rgseq_cfg.svh"

// Bit-time counter, advances only on bit-time strobes
module rgseq_bitcnt
    import rgseq_pkg::*;
#(
    parameter int W = `RGSEQ_CNT_W
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         start,
    input  wire logic         bit_tick,
    // Count
    output logic [W-1:0]      count
);
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = '0;
        end else if (bit_tick && count != {W{1'b1}}) begin
            // Saturate so a late reader never sees a wrapped small value
            next_count = count + W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : rgseq_bitcnt

// *** hdl/rgseq_top.sv ***
`include "rgseq_cfg.svh"

module rgseq_top
    import rgseq_pkg::*;
#(
    parameter int W   = `RGSEQ_CNT_W,
    parameter int PW  = `RGSEQ_PRE_W
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // Drive-side strobes, synchronous to ref_clk
    input  wire logic          bit_tick,
    input  wire logic          index_sector,
    input  wire logic          last_hdr_bit,
    // Operation control
    input  wire logic          start_read,
    input  wire rgseq_fmt_t    fmt_mode,
    input  wire logic          window_en,
    input  wire logic          format_pass,
    input  wire logic          one_pass_fmt,
    input  wire logic          hdr_bits_done,
    input  wire logic          dat_bits_done,
    // Drive and controller timing, bit times
    input  wire logic [W-1:0]  read_data_delay,
    input  wire logic [W-1:0]  write_data_delay,
    input  wire logic [W-1:0]  ctrl_readgate_negate_delay,
    input  wire logic [W-1:0]  mark_detect_skew,
    input  wire logic [W-1:0]  ctrl_mark_enable_negate_delay,
    input  wire logic [W-1:0]  ctrl_write_gate_assert_delay,
    input  wire logic [W-1:0]  write_splice_size,
    input  wire logic [W-1:0]  read_gate_window,
    input  wire logic [W-1:0]  ctrl_readgate_assert_delay,
    input  wire logic [W-1:0]  ctrl_write_splice,
    input  wire logic [PW-1:0] lock_preamble,
    input  wire logic [PW-1:0] fmt_extra_preamble,
    // Outputs
    output logic               read_gate,
    output logic               in_data_area,
    output logic               window_miss,
    output logic [W-1:0]       pad_len,
    output logic [W-1:0]       fmt_pad_len,
    output logic [PW-1:0]      fmt_preamble
);
    // ****************************************
    // Bit-time arithmetic
    // ****************************************
    function automatic logic [W-1:0] sat_sub(input logic [W-1:0] a, input logic [W-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction : sat_sub

    // Earliest point after the mark; own assert delay pulls the decision forward
    function automatic logic [W-1:0] hdr_min(input rgseq_fmt_t m);
        logic [W-1:0] base;
        base = '0;
        unique case (m)
            RGSEQ_ALT1: base = mark_detect_skew + ctrl_mark_enable_negate_delay;
            RGSEQ_ALT2: base = mark_detect_skew + ctrl_write_gate_assert_delay
                               + write_splice_size;
            RGSEQ_SOFT: base = mark_detect_skew;
            default:    base = '0;
        endcase
        hdr_min = base;
    endfunction : hdr_min

    logic [W-1:0] sum_pad;
    logic [W-1:0] t_min;
    logic [W-1:0] t_max;
    logic [W-1:0] t_dat;
    logic [W-1:0] fire_at;

    always_comb begin
        sum_pad  = read_data_delay + write_data_delay + ctrl_readgate_negate_delay;
        t_min    = hdr_min(fmt_mode);
        t_max    = t_min + read_gate_window;
        // Data gate from header gate negation: pad + own splice + drive splice
        t_dat    = pad_len + ctrl_write_splice + write_splice_size;
        // Issue at the earliest legal point less own read-gate assert delay
        fire_at  = sat_sub(t_min, ctrl_readgate_assert_delay);
    end

    // ****************************************
    // Sequencer
    // ****************************************
    rgseq_state_t state;
    rgseq_state_t next_state;
    logic         cnt_start;
    logic [W-1:0] count;
    logic [W-1:0] neg_cnt;
    logic         neg_pend;
    logic         next_read_gate;
    logic         next_in_data_area;
    logic         next_window_miss;
    logic [W-1:0] next_neg_cnt;
    logic         next_neg_pend;
    logic         dat_fire;

    rgseq_bitcnt #(
        .W (W)
    ) u_cnt (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .start    (cnt_start),
        .bit_tick (bit_tick),
        .count    (count)
    );

    always_comb begin
        next_state        = state;
        next_read_gate    = read_gate;
        next_in_data_area = in_data_area;
        next_window_miss  = window_miss;
        next_neg_cnt      = neg_cnt;
        next_neg_pend     = neg_pend;
        cnt_start         = 1'b0;
        // Data gate also issues early by own read-gate assert delay
        dat_fire          = count >= sat_sub(t_dat, ctrl_readgate_assert_delay);
        unique case (state)
            RGSEQ_IDLE: begin
                next_read_gate    = 1'b0;
                next_in_data_area = 1'b0;
                if (start_read && index_sector) begin
                    next_state       = RGSEQ_HDR_WAIT;
                    next_window_miss = 1'b0;
                    cnt_start        = 1'b1;
                end
            end
            RGSEQ_HDR_WAIT: begin
                if (count >= fire_at) begin
                    next_read_gate = 1'b1;
                    next_state     = RGSEQ_HDR_READ;
                    if (window_en && fmt_mode != RGSEQ_SOFT && count > t_max) begin
                        next_window_miss = 1'b1;
                    end
                end
            end
            RGSEQ_HDR_READ: begin
                // Negate delay counted from last header bit latch
                if (last_hdr_bit || hdr_bits_done) begin
                    next_neg_pend = 1'b1;
                    next_neg_cnt  = '0;
                end else if (neg_pend && bit_tick) begin
                    next_neg_cnt = neg_cnt + W'(1);
                end
                if (neg_pend && neg_cnt >= ctrl_readgate_negate_delay) begin
                    next_neg_pend  = 1'b0;
                    next_read_gate = 1'b0;
                    next_state     = RGSEQ_DAT_WAIT;
                    cnt_start      = 1'b1;
                end
            end
            RGSEQ_DAT_WAIT: begin
                if (dat_fire) begin
                    next_read_gate    = 1'b1;
                    next_in_data_area = 1'b1;
                    next_state        = RGSEQ_DAT_READ;
                end
            end
            RGSEQ_DAT_READ: begin
                if (dat_bits_done) begin
                    next_read_gate    = 1'b0;
                    next_in_data_area = 1'b0;
                    next_state        = RGSEQ_IDLE;
                end
            end
            default: next_state = RGSEQ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state        <= RGSEQ_IDLE;
            read_gate    <= 1'b0;
            in_data_area <= 1'b0;
            window_miss  <= 1'b0;
            neg_cnt      <= `RGSEQ_CNT_ZERO;
            neg_pend     <= 1'b0;
        end else begin
            state        <= next_state;
            read_gate    <= next_read_gate;
            in_data_area <= next_in_data_area;
            window_miss  <= next_window_miss;
            neg_cnt      <= next_neg_cnt;
            neg_pend     <= next_neg_pend;
        end
    end

    // ****************************************
    // Format pad and preamble
    // ****************************************
    logic [W-1:0]  next_pad_len;
    logic [W-1:0]  next_fmt_pad_len;
    logic [PW-1:0] next_fmt_preamble;

    always_comb begin
        next_pad_len     = sum_pad;
        // One-pass pad matches read propagation so the splice lands as on update
        next_fmt_pad_len = one_pass_fmt ? read_data_delay : '0;
        // Two-pass: long preamble first, then nominal on the rewrite pass
        next_fmt_preamble = (format_pass && !one_pass_fmt)
                          ? PW'(lock_preamble + fmt_extra_preamble)
                          : lock_preamble;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pad_len      <= `RGSEQ_CNT_ZERO;
            fmt_pad_len  <= `RGSEQ_CNT_ZERO;
            fmt_preamble <= '0;
        end else begin
            pad_len      <= next_pad_len;
            fmt_pad_len  <= next_fmt_pad_len;
            fmt_preamble <= next_fmt_preamble;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Decision edge is one before the rise, so look at the counter there
    a_hdr_gate_early: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(read_gate) && !in_data_area |-> $past(count) >= $past(fire_at))
        else $error("header gate asserted early");
    a_dat_gate_early: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(read_gate) && in_data_area |-> $past(dat_fire))
        else $error("data gate asserted early");
    a_pad_sum: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 pad_len == $past(sum_pad))
        else $error("pad length wrong");
    a_gate_off_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        state == RGSEQ_IDLE |=> !read_gate)
        else $error("gate on while idle");
    a_dat_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(read_gate) && state == RGSEQ_DAT_WAIT |-> count == '0)
        else $error("data timer not restarted");
    a_fmt_pad: assert property (@(posedge ref_clk) disable iff (!rstn)
        one_pass_fmt |=> fmt_pad_len == $past(read_data_delay))
        else $error("format pad wrong");
    a_fmt_pre: assert property (@(posedge ref_clk) disable iff (!rstn)
        !format_pass |=> fmt_preamble == $past(lock_preamble))
        else $error("rewrite preamble wrong");
    a_neg_delay: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(read_gate) && state == RGSEQ_DAT_WAIT
        |-> $past(neg_cnt) >= $past(ctrl_readgate_negate_delay))
        else $error("gate negated too soon");
endmodule : rgseq_top

// *** sim/rgseq_drive_model.sv ***
module rgseq_drive_model #(
    parameter int DIV = 2,
    parameter int HB  = 6
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Controller side
    input  wire logic sector_req,
    input  wire logic read_gate,
    input  wire logic in_data_area,
    // Drive strobes
    output logic      bit_tick,
    output logic      index_sector,
    output logic      last_hdr_bit,
    output logic      dat_bits_done
);
    timeunit 1ns;
    timeprecision 1ps;

    int div_cnt;
    int bits;

    // ****************************************
    // Bit clock, marks and field ends
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 0;
            bit_tick <= 1'b0;
            index_sector <= 1'b0;
            last_hdr_bit <= 1'b0;
            dat_bits_done <= 1'b0;
            bits <= 0;
        end else begin
            div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
            bit_tick <= (div_cnt == DIV - 1);
            index_sector <= sector_req;
            last_hdr_bit <= 1'b0;
            dat_bits_done <= 1'b0;
            // Field length counted only while the gate is open
            if (!read_gate) begin
                bits <= 0;
            end else if (bit_tick && bits < HB) begin
                bits <= bits + 1;
            end
            if (read_gate && bit_tick && bits == HB - 1) begin
                if (in_data_area) begin
                    dat_bits_done <= 1'b1;
                end else begin
                    last_hdr_bit <= 1'b1;
                end
            end
        end
    end
endmodule : rgseq_drive_model

// *** sim/tb.sv ***
module tb
    import rgseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk;
    logic        rstn;
    logic        bit_tick;
    logic        index_sector;
    logic        last_hdr_bit;
    logic        dat_bits_done;
    logic        sector_req;
    logic        start_read;
    rgseq_fmt_t  fmt_mode;
    logic        window_en;
    logic        format_pass;
    logic        one_pass_fmt;
    logic        use_done;
    logic [15:0] t [0:9];
    logic [7:0]  pre;
    logic [7:0]  ext;
    logic        read_gate;
    logic        in_data_area;
    logic        window_miss;
    logic [15:0] pad_len;
    logic [15:0] fmt_pad_len;
    logic [7:0]  fmt_preamble;
    int          failures;
    int          samples_checked;

    // Lines that span can wait on
    localparam int SEL_MARK    = 0;
    localparam int SEL_GATE    = 1;
    localparam int SEL_HDR_END = 2;
    localparam int SEL_DAT_END = 3;

    rgseq_top rgseq_top_i (.ref_clk(ref_clk), .rstn(rstn), .bit_tick(bit_tick),
        .index_sector(index_sector), .last_hdr_bit(last_hdr_bit & ~use_done),
        .start_read(start_read),
        .fmt_mode(fmt_mode), .window_en(window_en), .format_pass(format_pass),
        .one_pass_fmt(one_pass_fmt), .hdr_bits_done(last_hdr_bit & use_done),
        .dat_bits_done(dat_bits_done),
        .read_data_delay(t[0]), .write_data_delay(t[1]), .ctrl_readgate_negate_delay(t[2]),
        .mark_detect_skew(t[3]), .ctrl_mark_enable_negate_delay(t[4]),
        .ctrl_write_gate_assert_delay(t[5]), .write_splice_size(t[6]),
        .read_gate_window(t[7]), .ctrl_readgate_assert_delay(t[8]),
        .ctrl_write_splice(t[9]), .lock_preamble(pre), .fmt_extra_preamble(ext),
        .read_gate(read_gate), .in_data_area(in_data_area), .window_miss(window_miss),
        .pad_len(pad_len), .fmt_pad_len(fmt_pad_len), .fmt_preamble(fmt_preamble));

    rgseq_drive_model rgseq_drive_model_i (.ref_clk(ref_clk), .rstn(rstn),
        .sector_req(sector_req), .read_gate(read_gate), .in_data_area(in_data_area),
        .bit_tick(bit_tick), .index_sector(index_sector), .last_hdr_bit(last_hdr_bit),
        .dat_bits_done(dat_bits_done));

    task print_verdict;
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Tolerance of two ticks covers the divider phase at start and stop
    task rng(input string nm, input int lo, input int n);
        samples_checked++;
        if (n < lo || n > lo + 2) begin
            failures++;
            $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, lo + 2, n);
        end
    endtask : rng

    function automatic logic watch(input int sel);
        case (sel)
            SEL_MARK:    watch = index_sector;
            SEL_GATE:    watch = read_gate;
            SEL_HDR_END: watch = last_hdr_bit;
            default:     watch = dat_bits_done;
        endcase
    endfunction : watch

    // Counts bit ticks until the watched line reaches the level
    task automatic span(input int sel, input logic lvl, output int n);
        int i;
        n = 0;
        for (i = 0; i < 4000 && watch(sel) !== lvl; i++) begin
            @(posedge ref_clk);
            #1;
            if (bit_tick === 1'b1 && watch(sel) !== lvl) n++;
        end
        if (watch(sel) !== lvl) begin
            failures++;
            $display("MISMATCH wait exp level %b got timeout", lvl);
            print_verdict();
        end
    endtask : span

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin : main
        int n;
        int k;
        int tmin;
        int thr;
        int lead;
        failures = 0;
        samples_checked = 0;
        rstn = 1'b0;
        sector_req = 1'b0;
        start_read = 1'b0;
        fmt_mode = RGSEQ_ALT1;
        {window_en, format_pass, one_pass_fmt, use_done} = 4'h0;
        foreach (t[i]) t[i] = 16'h0000;
        pre = 8'h00;
        ext = 8'h00;
        void'($urandom(15211));
        repeat (10) @(posedge ref_clk);
        #1 rstn = 1'b1;
        for (k = 0; k < 12; k++) begin
            @(posedge ref_clk);
            #1;
            fmt_mode = rgseq_fmt_t'(k % 3);
            // Alternate the two end-of-header strobes
            use_done = 1'(k % 2);
            foreach (t[i]) t[i] = 16'($urandom_range(0, 12));
            window_en = 1'($urandom);
            format_pass = 1'($urandom);
            one_pass_fmt = ~format_pass & 1'($urandom);
            pre = 8'($urandom_range(1, 60));
            ext = 8'($urandom_range(0, 60));
            repeat (3) @(posedge ref_clk);
            #1;
            chk("pad_len", t[0] + t[1] + t[2], pad_len);
            chk("fmt_pad_len", one_pass_fmt ? t[0] : 16'h0000, fmt_pad_len);
            chk("fmt_preamble", format_pass ? pre + ext : pre, fmt_preamble);
            tmin = (k % 3 == 0) ? t[3] + t[4] : (k % 3 == 1) ? t[3] + t[5] + t[6] : t[3];
            thr = (tmin > t[8]) ? tmin - t[8] : 0;
            start_read = 1'b1;
            sector_req = 1'b1;
            @(posedge ref_clk);
            #1 sector_req = 1'b0;
            span(SEL_MARK, 1'b1, n);
            span(SEL_GATE, 1'b1, n);
            rng("hdr_gate_ticks", thr, n);
            chk("hdr_area", 16'h0000, 16'(in_data_area));
            // A second mark mid-read must be ignored
            sector_req = 1'b1;
            @(posedge ref_clk);
            #1 sector_req = 1'b0;
            span(SEL_HDR_END, 1'b1, n);
            span(SEL_GATE, 1'b0, n);
            rng("negate_ticks", t[2], n);
            thr = t[0] + t[1] + t[2] + t[9] + t[6];
            thr = (thr > t[8]) ? thr - t[8] : 0;
            // Data timer restarts on the negation edge, so the next tick counts
            lead = (bit_tick === 1'b1) ? 1 : 0;
            span(SEL_GATE, 1'b1, n);
            rng("dat_gate_ticks", thr, n + lead);
            chk("dat_area", 16'h0001, 16'(in_data_area));
            span(SEL_DAT_END, 1'b1, n);
            start_read = 1'b0;
            @(posedge ref_clk);
            #1;
            chk("gate_end", 16'h0000, {15'h0000, read_gate});
            chk("window_miss", 16'h0000, 16'(window_miss));
        end
        print_verdict();
    end
endmodule : tb
